/* hw/iepb_pkg.sv */
// constants, carriers and helpers for the interrupt enable/pending bank
package iepb_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_IRQ   = 240;
  localparam int NUM_WORDS = 8;
  localparam int WORD_W    = 32;
  localparam int PRIO_W    = 2;
  localparam int ID_W      = 8;
  localparam int ADDR_W    = 12;

  // ****************************************************************
  // register offsets inside the controller window, reset values
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_SET_ENABLE   = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_CLEAR_ENABLE = 12'h180;
  localparam logic [ADDR_W-1:0] OFF_SET_PENDING  = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_SEC_TARGET   = 12'h380;
  localparam int                REGION_LSB       = 6;
  localparam int                WORD_LSB         = 2;
  localparam logic [WORD_W-1:0] RST_ENABLE       = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_PENDING      = 32'h0000_0000;
  localparam logic [WORD_W-1:0] RST_TARGET       = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_ONE         = 32'h0000_0001;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic              nonSecure;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } iepb_req_s;

  typedef struct packed {
    logic              valid;
    logic [ID_W-1:0]   id;
    logic [PRIO_W-1:0] prio;
  } iepb_sel_s;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic regionHit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
    regionHit = (a[ADDR_W-1:REGION_LSB] == off[ADDR_W-1:REGION_LSB]);
  endfunction

  // bits above the implemented interrupt count are zero
  function automatic logic [WORD_W-1:0] implMask(input int w);
    logic [WORD_W-1:0] m;
    m = '0;
    for (int b = 0; b < WORD_W; b++) begin
      m[b] = ((w * WORD_W + b) < NUM_IRQ);
    end
    implMask = m;
  endfunction

endpackage

/* hw/iepb_word.sv */
// one 32-interrupt word of enable, pending and security target state
`timescale 1ns/1ps
module iepb_word
  import iepb_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [WORD_W-1:0] enSet,
  input  wire logic [WORD_W-1:0] enClr,
  input  wire logic [WORD_W-1:0] pendSet,
  input  wire logic [WORD_W-1:0] pendClr,
  input  wire logic              tgtWr,
  input  wire logic [WORD_W-1:0] tgtData,
  output logic      [WORD_W-1:0] enable_q,
  output logic      [WORD_W-1:0] pending_q,
  output logic      [WORD_W-1:0] target_q
);

  logic [WORD_W-1:0] enable_d;
  logic [WORD_W-1:0] pending_d;
  logic [WORD_W-1:0] target_d;

  assign enable_d  = (enable_q | enSet) & ~enClr;
  // set beats clear so a request in the ack cycle is kept
  // re-set keeps state
  assign pending_d = (pending_q & ~pendClr) | pendSet;
  assign target_d  = tgtWr ? tgtData : target_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_q  <= RST_ENABLE;
      pending_q <= RST_PENDING;
      target_q  <= RST_TARGET;
    end else begin
      enable_q  <= enable_d;
      pending_q <= pending_d;
      target_q  <= target_d;
    end
  end

endmodule // iepb_word

/* hw/iepb_arbiter.sv */
// picks the highest priority enabled pending interrupt, registered
`timescale 1ns/1ps
module iepb_arbiter
  import iepb_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic [NUM_IRQ-1:0]        cand,
  input  wire logic [NUM_IRQ*PRIO_W-1:0] prioLevels,
  output iepb_sel_s                      sel_q
);

  iepb_sel_s sel_d;

  // lower value wins; downward scan with <= leaves the lowest id on ties
  always_comb begin
    sel_d = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (cand[i] && (!sel_d.valid || prioLevels[i*PRIO_W +: PRIO_W] <= sel_d.prio)) begin
        sel_d.valid = 1'b1;
        sel_d.id    = ID_W'(i);
        sel_d.prio  = prioLevels[i*PRIO_W +: PRIO_W];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= '0;
    end else begin
      sel_q <= sel_d;
    end
  end

endmodule // iepb_arbiter

/* hw/irq_enable_pending_bank.sv */
// enable and pending register bank of the vectored interrupt controller
//
// Contract
// - set-enable view, write one enables, reads state
// - clear-enable view, write one disables, reads state
// - set-pending view, write one forces pending
// - set-pending reads show current pending bits
// - enabled pending interrupts presented by priority
// - disabled line still pends, never presented
// - set-pending on pending interrupt changes nothing
// - software pending ignores enable state
// - bits read zero, ignore writes per target
// - target bit zero secure, one non-secure
`timescale 1ns/1ps
module irq_enable_pending_bank
  import iepb_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  iepb_req_s                      regReq,
  input  wire logic [NUM_IRQ-1:0]        irqLines,
  input  wire logic [NUM_IRQ*PRIO_W-1:0] prioLevels,
  input  wire logic                      ackValid,
  input  wire logic [ID_W-1:0]           ackId,
  output logic      [WORD_W-1:0]         rdData_q,
  output logic                           rdValid_q,
  output iepb_sel_s                      present_q
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic [3:0]                         wordIdx;
  logic [2:0]                         wordSel;
  logic                               wordOk;
  logic                               hitSetEn;
  logic                               hitClrEn;
  logic                               hitSetPend;
  logic                               hitTarget;
  logic                               wrSetEn;
  logic                               wrClrEn;
  logic                               wrSetPend;
  logic                               wrTarget;
  logic [NUM_WORDS*WORD_W-1:0]        irqWide;

  assign wordIdx    = regReq.addr[WORD_LSB +: 4];
  assign wordSel    = wordIdx[2:0];
  // words 8..15 of each 16-word region are not built and read zero
  assign wordOk     = (wordIdx < 4'(NUM_WORDS));
  assign hitSetEn   = regionHit(regReq.addr, OFF_SET_ENABLE);
  assign hitClrEn   = regionHit(regReq.addr, OFF_CLEAR_ENABLE);
  assign hitSetPend = regionHit(regReq.addr, OFF_SET_PENDING);
  assign hitTarget  = regionHit(regReq.addr, OFF_SEC_TARGET);
  assign wrSetEn    = regReq.wrEn & hitSetEn & wordOk;
  assign wrClrEn    = regReq.wrEn & hitClrEn & wordOk;
  assign wrSetPend  = regReq.wrEn & hitSetPend & wordOk;
  // target word is reachable from secure accesses only
  assign wrTarget   = regReq.wrEn & hitTarget & wordOk & ~regReq.nonSecure;
  assign irqWide    = {{(NUM_WORDS*WORD_W-NUM_IRQ){1'b0}}, irqLines};

  // ****************************************************************
  // per-word state
  // ****************************************************************
  logic [NUM_WORDS-1:0][WORD_W-1:0] enableBits;
  logic [NUM_WORDS-1:0][WORD_W-1:0] pendingBits;
  logic [NUM_WORDS-1:0][WORD_W-1:0] targetBits;
  logic [NUM_WORDS-1:0][WORD_W-1:0] visMask;
  logic [NUM_WORDS-1:0][WORD_W-1:0] enSetV;
  logic [NUM_WORDS-1:0][WORD_W-1:0] enClrV;
  logic [NUM_WORDS-1:0][WORD_W-1:0] pendSetV;
  logic [NUM_WORDS-1:0][WORD_W-1:0] pendClrV;
  logic [NUM_WORDS-1:0]             wordHit;
  logic [NUM_WORDS-1:0]             tgtWrV;

  for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
    assign wordHit[w] = (wordSel == 3'(w));
    assign visMask[w] = implMask(w) & (regReq.nonSecure ? targetBits[w] : '1);
    assign enSetV[w]   = (wrSetEn && wordHit[w]) ? (regReq.wdata & visMask[w]) : '0;
    assign enClrV[w]   = (wrClrEn && wordHit[w]) ? (regReq.wdata & visMask[w]) : '0;
    assign pendSetV[w] = ((wrSetPend && wordHit[w]) ? (regReq.wdata & visMask[w]) : '0)
                       | (irqWide[w*WORD_W +: WORD_W] & implMask(w));
    // processor entering the handler drops the pending bit
    assign pendClrV[w] = (ackValid && ackId[7:5] == 3'(w)) ? (WORD_ONE << ackId[4:0]) : '0;
    assign tgtWrV[w]   = wrTarget & wordHit[w];

    iepb_word u_word (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .enSet     (enSetV[w]),
      .enClr     (enClrV[w]),
      .pendSet   (pendSetV[w]),
      .pendClr   (pendClrV[w]),
      .tgtWr     (tgtWrV[w]),
      .tgtData   (regReq.wdata & implMask(w)),
      .enable_q  (enableBits[w]),
      .pending_q (pendingBits[w]),
      .target_q  (targetBits[w])
    );
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [WORD_W-1:0] rdEnable;
  logic [WORD_W-1:0] rdPending;
  logic [WORD_W-1:0] rdTarget;
  logic [WORD_W-1:0] rdData_d;
  logic              rdValid_d;

  assign rdEnable  = wordOk ? (enableBits[wordSel] & visMask[wordSel]) : '0;
  assign rdPending = wordOk ? (pendingBits[wordSel] & visMask[wordSel]) : '0;
  assign rdTarget  = (wordOk && !regReq.nonSecure) ? targetBits[wordSel] : '0;
  assign rdData_d  = !regReq.rdEn              ? '0 :
                     (hitSetEn || hitClrEn)    ? rdEnable :
                     hitSetPend                ? rdPending :
                     hitTarget                 ? rdTarget : '0;
  assign rdValid_d = regReq.rdEn;

  // unmapped reads answer zero, still with a valid strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_q  <= '0;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q  <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  // ****************************************************************
  // arbitration
  // ****************************************************************
  logic [NUM_WORDS*WORD_W-1:0] candWide;

  assign candWide = enableBits & pendingBits;

  iepb_arbiter u_arb (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .cand       (candWide[NUM_IRQ-1:0]),
    .prioLevels (prioLevels),
    .sel_q      (present_q)
  );

endmodule // irq_enable_pending_bank

/* sim/iepb_checker.sv */
// port assertions for the enable and pending bank
`timescale 1ns/1ps
module iepb_checker
  import iepb_pkg::*;
(
  input wire logic                      ref_clk,
  input wire logic                      sys_rst,
  input iepb_req_s                      regReq,
  input wire logic [NUM_IRQ*PRIO_W-1:0] prioLevels,
  input wire logic [WORD_W-1:0]         rdData_q,
  input wire logic                      rdValid_q,
  input iepb_sel_s                      present_q
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire              sWr  = regReq.wrEn && !regReq.nonSecure;
  wire              sRd  = regReq.rdEn && !regReq.nonSecure;
  wire [ADDR_W-1:0] ad   = regReq.addr;
  wire [WORD_W-1:0] wdat = regReq.wdata;
  wire [5:0]        rg   = ad[11:6];
  a_read_answer: assert property (regReq.rdEn |=> rdValid_q)
    else $error("read not answered next cycle");
  a_idle_quiet: assert property (!regReq.rdEn |=> !rdValid_q && rdData_q == '0)
    else $error("read data without read");
  a_set_enable: assert property (sWr && ad == 12'h100 ##1 sRd && ad == 12'h100
    |=> (rdData_q & $past(wdat, 2)) == $past(wdat, 2)) else $error("enable not set");
  a_clear_enable: assert property (sWr && ad == 12'h180 ##1 sRd && ad == 12'h100
    |=> (rdData_q & $past(wdat, 2)) == '0) else $error("enable not cleared");
  a_set_pending: assert property (sWr && ad == 12'h204 ##1 sRd && ad == 12'h204
    |=> (rdData_q & $past(wdat, 2)) == $past(wdat, 2)) else $error("pending not set");
  a_high_zero: assert property (regReq.rdEn && (rg == 6'h04 || rg == 6'h06 ||
    rg == 6'h08) && ad[5:2] >= 4'h7 |=> rdData_q[31:16] == '0) else $error("high bits");
  a_target_hidden: assert property (regReq.rdEn && regReq.nonSecure && rg == 6'h0e
    |=> rdData_q == '0) else $error("target visible to non-secure");
  a_present_range: assert property (present_q.valid |-> present_q.id < NUM_IRQ)
    else $error("presented id out of range");
  a_present_prio: assert property (present_q.valid && $stable(prioLevels) &&
    $past(prioLevels, 2) == prioLevels |-> present_q.prio == prioLevels[2*present_q.id +: 2])
    else $error("presented priority wrong");
endmodule // iepb_checker

bind irq_enable_pending_bank iepb_checker iepb_checker_inst (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .regReq(regReq), .prioLevels(prioLevels), .rdData_q(rdData_q),
  .rdValid_q(rdValid_q), .present_q(present_q));

/* sim/iepb_partner.sv */
// peripheral request lines and core acknowledge model
`timescale 1ns/1ps
module iepb_partner
  import iepb_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic [NUM_IRQ-1:0] lineReq,
  input  wire logic               ackReq,
  input  iepb_sel_s               present_q,
  output logic      [NUM_IRQ-1:0] irqLines,
  output logic                    ackValid,
  output logic      [ID_W-1:0]    ackId
);
  initial begin
    irqLines = '0;
    ackValid = 1'b0;
    ackId = '0;
  end
  // core only acks when told, so the bench owns pending timing
  always @(negedge ref_clk) begin
    irqLines <= lineReq;
    ackValid <= ackReq && present_q.valid;
    ackId <= ackReq ? present_q.id : ~ackId;
  end
endmodule // iepb_partner

/* sim/tb_top.sv */
// self-checking bench for the enable and pending bank
`timescale 1ns/1ps
module tb_top;
  import iepb_pkg::*;
  logic                      ref_clk, sys_rst, ackReq, ackValid, rdValid_q;
  logic [NUM_IRQ-1:0]        lineReq, irqLines;
  logic [NUM_IRQ*PRIO_W-1:0] prioLevels;
  logic [ID_W-1:0]           ackId;
  logic [WORD_W-1:0]         rdData_q;
  iepb_req_s                 regReq;
  iepb_sel_s                 present_q;
  int                        err_count = 0;
  int                        checks_done = 0;
  irq_enable_pending_bank irq_enable_pending_bank_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .regReq(regReq), .irqLines(irqLines), .prioLevels(prioLevels), .ackValid(ackValid),
    .ackId(ackId), .rdData_q(rdData_q), .rdValid_q(rdValid_q), .present_q(present_q));
  iepb_partner iepb_partner_inst (.ref_clk(ref_clk), .lineReq(lineReq), .ackReq(ackReq),
    .present_q(present_q), .irqLines(irqLines), .ackValid(ackValid), .ackId(ackId));
  // ****************************************************************
  // bus tasks: each entered at a falling edge, wr and rd hold the request one cycle, idle holds n cycles
  // ****************************************************************
  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic ok, input logic [ADDR_W-1:0] a);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t check at %h", $time, a);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d, input logic ns);
    regReq <= '{1'b1, 1'b0, ns, a, d};
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic ns, input logic [WORD_W-1:0] e);
    regReq <= '{1'b0, 1'b1, ns, a, 32'h0000_0000};
    @(negedge ref_clk);
    cmp((rdValid_q === 1'b1) && (rdData_q === e), a);
  endtask
  task automatic idle(input int n);
    regReq <= '0;
    repeat (n) @(negedge ref_clk);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic s_enable();
    wr(12'h100, 32'h0000_00a5, 1'b0);
    rd(12'h100, 1'b0, 32'h0000_00a5);
    rd(12'h180, 1'b0, 32'h0000_00a5);
    wr(12'h180, 32'h0000_0005, 1'b0);
    rd(12'h100, 1'b0, 32'h0000_00a0);
    wr(12'h100, 32'h0000_0000, 1'b0);
    rd(12'h100, 1'b0, 32'h0000_00a0);
  endtask
  task automatic s_pending();
    rd(12'h204, 1'b0, 32'h0000_0000);
    wr(12'h204, 32'h0000_0100, 1'b0);
    rd(12'h204, 1'b0, 32'h0000_0100);
    wr(12'h204, 32'h0000_0100, 1'b0);
    rd(12'h204, 1'b0, 32'h0000_0100);
    idle(3);
    cmp(present_q.valid === 1'b0, 12'h204);
  endtask
  task automatic s_arbitrate();
    lineReq <= 240'h02a0;
    idle(1);
    lineReq <= '0;
    idle(5);
    cmp(present_q === iepb_sel_s'{1'b1, 8'h07, 2'h1}, 12'h007);
    rd(12'h200, 1'b0, 32'h0000_02a0);
    ackReq <= 1'b1;
    idle(1);
    ackReq <= 1'b0;
    idle(5);
    cmp(present_q === iepb_sel_s'{1'b1, 8'h05, 2'h2}, 12'h005);
  endtask
  task automatic s_security();
    wr(12'h380, 32'h0000_00f0, 1'b0);
    rd(12'h380, 1'b0, 32'h0000_00f0);
    rd(12'h380, 1'b1, 32'h0000_0000);
    rd(12'h100, 1'b1, 32'h0000_00a0);
    wr(12'h100, 32'hffff_ffff, 1'b1);
    rd(12'h100, 1'b0, 32'h0000_00f0);
    rd(12'h200, 1'b1, 32'h0000_0020);
    wr(12'h380, 32'hffff_ffff, 1'b1);
    rd(12'h380, 1'b0, 32'h0000_00f0);
  endtask
  task automatic s_range();
    wr(12'h11c, 32'hffff_ffff, 1'b0);
    rd(12'h11c, 1'b0, 32'h0000_ffff);
    rd(12'h120, 1'b0, 32'h0000_0000);
    rd(12'h000, 1'b0, 32'h0000_0000);
  endtask
  // ****************************************************************
  // clock, reset, sequence, watchdog
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    sys_rst = 1'b1;
    regReq = '0;
    lineReq = '0;
    ackReq = 1'b0;
    prioLevels = {NUM_IRQ{2'h3}};
    prioLevels[11:10] = 2'h2;
    prioLevels[15:14] = 2'h1;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    s_enable();
    s_pending();
    s_arbitrate();
    s_security();
    s_range();
    idle(2);
    tally_and_finish();
  end
  // whole sequence needs well under two hundred cycles
  initial begin
    repeat (1000) @(posedge ref_clk);
    err_count++;
    tally_and_finish();
  end
endmodule // tb_top
